// file: hw/cmp_ctrl_pkg.sv
// constants for the comparator control and status block
package cmp_ctrl_pkg;
  localparam logic [0:0] ADDR_CONTROL = 1'h0;
  localparam logic [0:0] ADDR_MODE = 1'h1;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_LEVEL = 6;
  localparam int CTL_RISE = 5;
  localparam int CTL_FALL = 4;
  localparam int CTL_POS_HYST = 2;
  localparam int CTL_NEG_HYST = 0;
  localparam int MD_RISE_IE = 5;
  localparam int MD_FALL_IE = 4;
  localparam int MD_RESP = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_5MV = 2'h1;
  localparam logic [1:0] HYST_10MV = 2'h2;
  localparam logic [1:0] HYST_20MV = 2'h3;
  localparam int SYNC_STAGES = 2;
endpackage

// file: hw/sticky_edge_flag.sv
// one sticky edge flag with software clear; set wins over clear
module sticky_edge_flag (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      if (set_i) begin
        flag_o <= 1'b1;
      end else if (clr_i) begin
        flag_o <= 1'b0;
      end
    end
  end

  a_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      flag_o && !(ce_i && clr_i) |=> flag_o)
    else $error("edge flag dropped without a clear");
  a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && set_i && clr_i |=> flag_o)
    else $error("clear beat a same-cycle edge");
endmodule

// file: hw/comparator_control_logic.sv
// comparator control and status registers, edge flags and outputs
//
// Design decisions made here: the plain strobed port and the placing of the registers.
module comparator_control_logic #(
  parameter int SYNC_STAGES = cmp_ctrl_pkg::SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cmp_analog_i,
  output logic cmp_raw_out_o,
  output logic cmp_sync_out_o,
  output logic cmp_power_o,
  output logic [1:0] pos_hyst_o,
  output logic [1:0] neg_hyst_o,
  output logic [1:0] resp_time_o,
  output logic irq_o,
  output logic reset_src_o
);
  initial begin
    if (SYNC_STAGES != 2) $error("only a two-stage synchroniser plus edge stage is built");
  end

  logic cmp_enable_bit;
  logic [1:0] pos_hyst_sel;
  logic [1:0] neg_hyst_sel;
  logic rise_irq_enable;
  logic fall_irq_enable;
  logic [1:0] resp_time_sel;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic cmp_level_bit;
  logic rise_edge_flag;
  logic fall_edge_flag;
  logic wr_ctl;
  logic wr_md;
  logic rise_evt;
  logic fall_evt;
  logic raw_q;

  assign wr_ctl = wr_i && addr_i == cmp_ctrl_pkg::ADDR_CONTROL;
  assign wr_md = wr_i && addr_i == cmp_ctrl_pkg::ADDR_MODE;

  // control register fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmp_enable_bit <= cmp_ctrl_pkg::CONTROL_RESET[cmp_ctrl_pkg::CTL_ENABLE];
      pos_hyst_sel <= cmp_ctrl_pkg::CONTROL_RESET[cmp_ctrl_pkg::CTL_POS_HYST +: 2];
      neg_hyst_sel <= cmp_ctrl_pkg::CONTROL_RESET[cmp_ctrl_pkg::CTL_NEG_HYST +: 2];
    end else if (ce_i && wr_ctl) begin
      cmp_enable_bit <= wdata_i[cmp_ctrl_pkg::CTL_ENABLE];
      pos_hyst_sel <= wdata_i[cmp_ctrl_pkg::CTL_POS_HYST +: 2];
      neg_hyst_sel <= wdata_i[cmp_ctrl_pkg::CTL_NEG_HYST +: 2];
    end
  end

  // mode register fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rise_irq_enable <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MD_RISE_IE];
      fall_irq_enable <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MD_FALL_IE];
      resp_time_sel <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MD_RESP +: 2];
    end else if (ce_i && wr_md) begin
      rise_irq_enable <= wdata_i[cmp_ctrl_pkg::MD_RISE_IE];
      fall_irq_enable <= wdata_i[cmp_ctrl_pkg::MD_FALL_IE];
      resp_time_sel <= wdata_i[cmp_ctrl_pkg::MD_RESP +: 2];
    end
  end

  // raw path has no flop on purpose: it must work with the clock stopped
  assign cmp_raw_out_o = cmp_analog_i && cmp_enable_bit;

  // gated result enters the synchroniser; disabled reads low
  assign raw_q = cmp_analog_i && cmp_enable_bit;

  // sync_a feeds only sync_b; edges taken when sync_b and sync_c agree, against cmp_level_bit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else if (ce_i) begin
      sync_a <= raw_q;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // level changes only once two stages agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmp_level_bit <= 1'b0;
    end else if (ce_i && sync_b == sync_c) begin
      cmp_level_bit <= sync_c;
    end
  end

  assign rise_evt = ce_i && (sync_b == sync_c) && sync_c && !cmp_level_bit;
  assign fall_evt = ce_i && (sync_b == sync_c) && !sync_c && cmp_level_bit;

  sticky_edge_flag rise_flag_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .set_i(rise_evt),
    .clr_i(wr_ctl && !wdata_i[cmp_ctrl_pkg::CTL_RISE]),
    .flag_o(rise_edge_flag)
  );

  sticky_edge_flag fall_flag_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .set_i(fall_evt),
    .clr_i(wr_ctl && !wdata_i[cmp_ctrl_pkg::CTL_FALL]),
    .flag_o(fall_edge_flag)
  );

  // registered outputs toward the analog cell, pins and system
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmp_sync_out_o <= 1'b0;
      cmp_power_o <= 1'b0;
      pos_hyst_o <= cmp_ctrl_pkg::HYST_OFF;
      neg_hyst_o <= cmp_ctrl_pkg::HYST_OFF;
      resp_time_o <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MD_RESP +: 2];
      reset_src_o <= 1'b0;
    end else if (ce_i) begin
      cmp_sync_out_o <= cmp_level_bit && cmp_enable_bit;
      cmp_power_o <= cmp_enable_bit;
      pos_hyst_o <= pos_hyst_sel;
      neg_hyst_o <= neg_hyst_sel;
      resp_time_o <= resp_time_sel;
      reset_src_o <= cmp_level_bit && cmp_enable_bit;
    end
  end

  // interrupt request, masked per edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= (rise_edge_flag && rise_irq_enable) ||
               (fall_edge_flag && fall_irq_enable);
    end
  end

  // read data; stands in the cycle after the read strobe, and longer only while ce_i is held low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (rd_i) begin
        if (addr_i == cmp_ctrl_pkg::ADDR_CONTROL) begin
          rdata_o <= {cmp_enable_bit, cmp_level_bit, rise_edge_flag, fall_edge_flag,
                      pos_hyst_sel, neg_hyst_sel};
        end else begin
          rdata_o <= {2'b00, rise_irq_enable, fall_irq_enable, 2'b00, resp_time_sel};
        end
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  a_raw_low_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cmp_enable_bit |-> !cmp_raw_out_o)
    else $error("raw output high while disabled");
  a_sync_low_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !cmp_enable_bit |=> !cmp_sync_out_o)
    else $error("synced output high while disabled");
  a_rise_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rise_evt |=> rise_edge_flag)
    else $error("rising edge did not set flag");
  a_fall_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fall_evt |=> fall_edge_flag)
    else $error("falling edge did not set flag");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !(rise_edge_flag && rise_irq_enable) && !(fall_edge_flag && fall_irq_enable)
      |=> !irq_o)
    else $error("interrupt without enabled flag");
  a_level_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && $rose(raw_q) ##1 (ce_i && raw_q) [*4] |=> cmp_level_bit)
    else $error("level bit missed a steady high");
  a_enable_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_ctl |=> cmp_enable_bit == $past(wdata_i[cmp_ctrl_pkg::CTL_ENABLE]))
    else $error("enable bit not written");
  a_mode_reset: assert property (@(posedge clk_i)
      !rst_n_i |=> resp_time_sel == 2'h2)
    else $error("mode field reset value wrong");
  a_read_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && rd_i && addr_i == cmp_ctrl_pkg::ADDR_CONTROL
      |=> rdata_o[cmp_ctrl_pkg::CTL_LEVEL] == $past(cmp_level_bit))
    else $error("read level mismatch");

  a_irq_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && rise_edge_flag && rise_irq_enable |=> irq_o)
    else $error("enabled rising flag gave no interrupt");
  a_irq_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && fall_edge_flag && fall_irq_enable |=> irq_o)
    else $error("enabled falling flag gave no interrupt");
  a_sync_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> cmp_sync_out_o == ($past(cmp_level_bit) && $past(cmp_enable_bit)))
    else $error("synced output does not follow level");
  a_reset_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> reset_src_o == ($past(cmp_level_bit) && $past(cmp_enable_bit)))
    else $error("reset source does not follow level");
  a_power_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> cmp_power_o == $past(cmp_enable_bit))
    else $error("power output does not follow enable");
  a_pos_hyst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> pos_hyst_o == $past(pos_hyst_sel))
    else $error("positive hysteresis output wrong");
  a_neg_hyst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> neg_hyst_o == $past(neg_hyst_sel))
    else $error("negative hysteresis output wrong");
  a_resp_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> resp_time_o == $past(resp_time_sel))
    else $error("response time output wrong");
  a_mode_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_md |=> resp_time_sel == $past(wdata_i[cmp_ctrl_pkg::MD_RESP +: 2]))
    else $error("mode field not written");
  a_hyst_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_ctl |=> neg_hyst_sel == $past(wdata_i[cmp_ctrl_pkg::CTL_NEG_HYST +: 2]))
    else $error("hysteresis field not written");
  a_rise_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && wr_ctl && !wdata_i[cmp_ctrl_pkg::CTL_RISE] && !rise_evt
      |=> !rise_edge_flag)
    else $error("rising flag survived a clear");
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_freeze_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !ce_i |=> $stable(rdata_o) && $stable(irq_o) && $stable(cmp_sync_out_o))
    else $error("state moved while clock enable low");

  // main scenarios worth seeing at least once
  c_rise_irq: cover property (@(posedge clk_i) rise_edge_flag && rise_irq_enable ##1 irq_o);
  c_fall_irq: cover property (@(posedge clk_i) fall_edge_flag && fall_irq_enable ##1 irq_o);
  c_set_and_clear: cover property (@(posedge clk_i) rise_evt && wr_ctl);
  c_disable: cover property (@(posedge clk_i) $fell(cmp_enable_bit));
  c_fall_edge: cover property (@(posedge clk_i) fall_evt);
endmodule

// file: bench/sfr_master.sv
// processor-side model that issues single-cycle register writes and reads
module sfr_master (
  input wire logic clk_i,
  output logic addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_o = 1'b0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one strobe cycle; afterwards the idle bus carries inverted junk, not the last value
  task automatic cycle(input logic w, input logic a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench for the comparator control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic addr, wr, rd, rd_q, cmp_analog, ce;
  logic [7:0] wdata, rdata, r;
  logic raw_out, sync_out, power, irq, reset_src;
  logic [1:0] pos_hyst, neg_hyst, resp_time;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  always #5 clk_i = ~clk_i;

  sfr_master cpu (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  comparator_control_logic dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmp_analog_i(cmp_analog),
    .cmp_raw_out_o(raw_out), .cmp_sync_out_o(sync_out), .cmp_power_o(power),
    .pos_hyst_o(pos_hyst), .neg_hyst_o(neg_hyst), .resp_time_o(resp_time),
    .irq_o(irq), .reset_src_o(reset_src)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr_reg(input logic a, input logic [7:0] d);
    cpu.cycle(1'b1, a, d);
  endtask

  // expected read value is queued; the monitor below compares it
  task automatic rd_reg(input logic a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.cycle(1'b0, a, 8'h00);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  always @(posedge clk_i) rd_q <= rd;
  always @(negedge clk_i) begin
    if (rd_q === 1'b1) begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end

  // generous ceiling: the sequence needs well under 300 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    cmp_analog = 1'b0;
    ce = 1'b1;
    void'($urandom(32'h38a698c8));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_reg(1'b0, 8'h00);
    rd_reg(1'b1, 8'h02);
    chk("resp_time", 8'h02, {6'h00, resp_time});
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr_reg(1'b0, 8'h8F);
    ce <= 1'b1;
    rd_reg(1'b0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      // writing 1 to the read-only level bit and to the flags changes nothing
      wr_reg(1'b0, 8'hF0 | 8'(i << 2) | 8'(3 - i));
      tick(1);
      chk("pos_hyst", 8'(i), {6'h00, pos_hyst});
      chk("neg_hyst", 8'(3 - i), {6'h00, neg_hyst});
      chk("power", 8'h01, {7'h00, power});
      rd_reg(1'b0, 8'h80 | 8'(i << 2) | 8'(3 - i));
    end
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom());
      wr_reg(1'b1, r);
      tick(1);
      chk("resp_time", {6'h00, r[1:0]}, {6'h00, resp_time});
      rd_reg(1'b1, r & 8'h33);
    end
    wr_reg(1'b1, 8'h23);
    @(posedge clk_i);
    cmp_analog <= 1'b1;
    #1;
    chk("raw_out", 8'h01, {7'h00, raw_out});
    tick(6);
    chk("sync_out", 8'h01, {7'h00, sync_out});
    chk("reset_src", 8'h01, {7'h00, reset_src});
    chk("irq", 8'h01, {7'h00, irq});
    rd_reg(1'b0, 8'hEC);
    tick(20);
    rd_reg(1'b0, 8'hEC);
    wr_reg(1'b0, 8'h9C);
    tick(2);
    chk("irq", 8'h00, {7'h00, irq});
    rd_reg(1'b0, 8'hCC);
    @(posedge clk_i);
    cmp_analog <= 1'b0;
    tick(6);
    rd_reg(1'b0, 8'h9C);
    chk("irq", 8'h00, {7'h00, irq});
    wr_reg(1'b1, 8'h13);
    tick(2);
    chk("irq", 8'h01, {7'h00, irq});
    wr_reg(1'b0, 8'h00);
    @(posedge clk_i);
    cmp_analog <= 1'b1;
    tick(6);
    chk("raw_out", 8'h00, {7'h00, raw_out});
    chk("sync_out", 8'h00, {7'h00, sync_out});
    chk("power", 8'h00, {7'h00, power});
    rd_reg(1'b0, 8'h00);
    tick(3);
    end_of_test();
  end
endmodule
